// *** ua_pkg.sv ***
// Purpose: Constants and types for the host-facing serial port
// Assumes: 100 MHz mclk, 16-bit register port with byte addresses
// Notes: One register per word, unmapped reads return zero
// Contract
// - The port offers eight host lines: data, flow control and modem lines.
// - The device drives rxd, dsr, dcd, ri and samples txd and dtr.
// - The device drives cts and samples rts for hardware flow control.
// - Flow control is hardware (reset default), software or none.
// - Cts is OFF whenever the port cannot take data, power saving included.
// - Power saving may follow the rts or the dtr line, as configured.
// - Twelve rates are offered, 115200 when rate detection is off.
// - Rate detection runs once at start-up; later only a write changes it.
// - Six formats are offered, 8N1 when format detection is off.
// - Format detection runs once at start-up with rate detection.
// - Low is a zero bit or ON, high is a one bit or OFF.
`default_nettype none
package ua_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int DIV_W = 14;
  localparam logic [DIV_W-1:0] DIV_ONE = 14'h0001;
  localparam int unsigned RATES [12] = '{
    9600, 19200, 38400, 57600, 115200, 230400,
    460800, 921600, 3000000, 3250000, 6000000, 6500000};
  localparam logic [3:0] BAUD_RST = 4'h4;
  localparam logic [3:0] BAUD_MAX = 4'hb;
  localparam logic [2:0] FMT_8N2 = 3'h0;
  localparam logic [2:0] FMT_8N1 = 3'h1;
  localparam logic [2:0] FMT_8E1 = 3'h2;
  localparam logic [2:0] FMT_8O1 = 3'h3;
  localparam logic [2:0] FMT_7E1 = 3'h4;
  localparam logic [2:0] FMT_7O1 = 3'h5;
  localparam logic [2:0] FMT_RST = FMT_8N1;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BAUD = 8'h04;
  localparam logic [7:0] A_FRAME = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_SEND = 8'h10;
  localparam logic [7:0] A_RECV = 8'h14;
  localparam int C_FLOW = 0;
  localparam int C_PSV_EN = 2;
  localparam int C_PSV_DTR = 3;
  localparam int C_ABD_EN = 4;
  localparam int C_DSR = 5;
  localparam int C_DCD = 6;
  localparam int C_RI = 7;
  localparam logic [7:0] CTRL_RST = 8'h10;
  localparam logic [1:0] FLOW_HW = 2'h0;
  localparam logic [1:0] FLOW_SW = 2'h1;
  localparam int S_OVR = 2;
  localparam int S_FERR = 3;
  localparam int S_PERR = 4;
  localparam logic [7:0] XON = 8'h11;
  localparam logic [7:0] XOFF = 8'h13;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;
  localparam logic [3:0] CTS_LVL = 4'h6;
  localparam logic [15:0] AB_MIN = 16'h0008;
  localparam logic [3:0] AB_LAST = 4'h8;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ua_bus_t;
  typedef struct packed {
    logic bits8;
    logic par;
    logic odd;
    logic stop2;
  } ua_fmt_t;
  typedef enum logic [4:0] {
    LN_IDLE = 5'b00001, LN_START = 5'b00010, LN_DATA = 5'b00100,
    LN_PAR = 5'b01000, LN_STOP = 5'b10000} ua_ln_t;
  typedef enum logic [3:0] {
    AB_WAIT = 4'b0001, AB_LOW = 4'b0010, AB_FRM = 4'b0100,
    AB_DONE = 4'b1000} ua_abd_t;

  function automatic logic [DIV_W-1:0] div_of(input logic [3:0] i);
    int unsigned r;
    r = RATES[(i > BAUD_MAX) ? BAUD_MAX : i];
    return DIV_W'((CLK_HZ + r / 2) / r);
  endfunction : div_of

  // Nearest rate to a measured start bit width
  function automatic logic [3:0] abd_pick(input logic [15:0] w);
    logic [3:0] b;
    int unsigned d;
    int unsigned bd;
    b = 4'h0;
    bd = 32'hffffffff;
    for (int i = 0; i < 12; i++) begin
      d = (32'(w) > 32'(div_of(4'(i)))) ? 32'(w) - 32'(div_of(4'(i)))
                                      : 32'(div_of(4'(i))) - 32'(w);
      if (d < bd) begin
        bd = d;
        b = 4'(i);
      end
    end
    return b;
  endfunction : abd_pick

  function automatic ua_fmt_t fmt_of(input logic [2:0] f);
    case (f)
      FMT_8N2: return '{1'b1, 1'b0, 1'b0, 1'b1};
      FMT_8E1: return '{1'b1, 1'b1, 1'b0, 1'b0};
      FMT_8O1: return '{1'b1, 1'b1, 1'b1, 1'b0};
      FMT_7E1: return '{1'b0, 1'b1, 1'b0, 1'b0};
      FMT_7O1: return '{1'b0, 1'b1, 1'b1, 1'b0};
      default: return '{1'b1, 1'b0, 1'b0, 1'b0};
    endcase
  endfunction : fmt_of
endpackage : ua_pkg
`default_nettype wire

// *** ua_fifo.sv ***
// Purpose: Small FIFO with registered read data
// Assumes: D is a power of two
// Notes: Head word is prefetched so out_data is a flop
`default_nettype none
module ua_fifo #(parameter int W = 8, parameter int D = 8) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // Fill level
  output logic [$clog2(D):0] level
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW-1:0] rp_n;
  logic [PW:0] cnt_q;
  logic [W-1:0] out_q;
  logic push;
  logic pop;

  assign in_ready = cnt_q != (PW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign rp_n = rp_q + PW'(1);
  assign out_data = out_q;
  assign level = cnt_q;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + PW'(1);
      end
      if (pop) begin
        rp_q <= rp_n;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Write-through when the new word becomes the head
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      out_q <= '0;
    end else if (push && (cnt_q == '0 || (pop && cnt_q == (PW+1)'(1)))) begin
      out_q <= in_data;
    end else if (pop) begin
      out_q <= mem_q[rp_n];
    end
  end
endmodule : ua_fifo
`default_nettype wire

// *** ua_tick.sv ***
// Purpose: Bit-time strobe generator
// Assumes: period of at least two cycles
// Notes: First strobe comes first+1 cycles after load
`default_nettype none
module ua_tick #(parameter int W = 14) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic load,
  input wire logic [W-1:0] first,
  input wire logic [W-1:0] period,
  // Strobe
  output logic tick
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= first;
    end else if (cnt_q == '0) begin
      cnt_q <= period - W'(1);
    end else begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign tick = !load && (cnt_q == '0);
endmodule : ua_tick
`default_nettype wire

// *** ua_port.sv ***
// Purpose: Host-facing asynchronous serial port with one-shot detection
// Assumes: Host lines synchronous to mclk, host keeps its rate and format
// Notes: Received characters wait in a FIFO until software reads them
//
// The placing of the registers and strobed register access were left to the implementer.
`default_nettype none
module ua_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire ua_pkg::ua_bus_t bus,
  output logic [15:0] rdata,
  // Host lines, low is ON or zero
  input wire logic txd,
  input wire logic rts_n,
  input wire logic dtr_n,
  output logic rxd,
  output logic cts_n,
  output logic dsr_n,
  output logic dcd_n,
  output logic ri_n,
  // Power saving state
  output logic psv_sleep
);
  localparam int DW = ua_pkg::DIV_W;

  logic [7:0] ctrl_q;
  logic [3:0] baud_q;
  logic [2:0] fmt_q;
  logic abd_done_q;
  logic ovr_q;
  logic ferr_q;
  logic perr_q;
  logic xoff_q;
  logic [15:0] rdata_q;
  logic sleep_q;
  logic cts_q;
  logic dsr_q;
  logic dcd_q;
  logic ri_q;
  ua_pkg::ua_fmt_t fmt;
  logic [DW-1:0] div;
  logic wr_ctrl;
  logic wr_baud;
  logic wr_fmt;
  logic wr_stat;
  logic wr_send;
  logic rd_recv;
  logic [1:0] flow;
  logic abd_run;
  logic rx_en;
  logic sleep_d;
  logic [15:0] stat;

  assign fmt = ua_pkg::fmt_of(fmt_q);
  assign div = ua_pkg::div_of(baud_q);
  assign wr_ctrl = bus.wr && bus.addr == ua_pkg::A_CTRL;
  assign wr_baud = bus.wr && bus.addr == ua_pkg::A_BAUD;
  assign wr_fmt = bus.wr && bus.addr == ua_pkg::A_FRAME;
  assign wr_stat = bus.wr && bus.addr == ua_pkg::A_STAT;
  assign wr_send = bus.wr && bus.addr == ua_pkg::A_SEND;
  assign rd_recv = bus.rd && bus.addr == ua_pkg::A_RECV;
  assign flow = ctrl_q[ua_pkg::C_FLOW +: 2];
  assign abd_run = ctrl_q[ua_pkg::C_ABD_EN] && !abd_done_q;
  assign rx_en = !abd_run;

  // Control register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= ua_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= bus.wdata[7:0];
    end
  end

  // Start-up detection of rate and format
  ua_pkg::ua_abd_t ab_q;
  logic [15:0] ab_cnt_q;
  logic [3:0] ab_k_q;
  logic [8:0] ab_smp_q;
  logic [3:0] ab_pick;
  logic [2:0] ab_fmt;
  logic ab_edge;

  assign ab_pick = ua_pkg::abd_pick(ab_cnt_q);
  assign ab_edge = ab_q == ua_pkg::AB_LOW && txd && ab_cnt_q >= ua_pkg::AB_MIN;
  // Expects an 'A' first; 8O1, 8N2 and 7E1 cannot be told from 8N1 this way
  assign ab_fmt = ab_smp_q[7] ? ua_pkg::FMT_7O1
                : (!ab_smp_q[8] ? ua_pkg::FMT_8E1 : ua_pkg::FMT_8N1);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ab_q <= ua_pkg::AB_WAIT;
      ab_cnt_q <= '0;
      ab_k_q <= '0;
      ab_smp_q <= '0;
    end else if (!abd_run) begin
      ab_q <= ua_pkg::AB_WAIT;
    end else begin
      case (ab_q)
        ua_pkg::AB_WAIT: begin
          if (!txd) begin
            ab_q <= ua_pkg::AB_LOW;
            ab_cnt_q <= 16'h0001;
          end
        end
        ua_pkg::AB_LOW: begin
          if (ab_edge) begin
            ab_q <= ua_pkg::AB_FRM;
            ab_k_q <= '0;
            ab_cnt_q <= 16'({1'b0, ua_pkg::div_of(ab_pick)} >> 1);
          end else if (txd) begin
            ab_q <= ua_pkg::AB_WAIT;
          end else if (ab_cnt_q != '1) begin
            ab_cnt_q <= ab_cnt_q + 16'h0001;
          end
        end
        ua_pkg::AB_FRM: begin
          if (ab_cnt_q == '0) begin
            ab_smp_q[ab_k_q] <= txd;
            ab_k_q <= ab_k_q + 4'h1;
            ab_cnt_q <= 16'(div) - 16'h0001;
            if (ab_k_q == ua_pkg::AB_LAST) begin
              ab_q <= ua_pkg::AB_DONE;
            end
          end else begin
            ab_cnt_q <= ab_cnt_q - 16'h0001;
          end
        end
        ua_pkg::AB_DONE: ab_q <= ua_pkg::AB_DONE;
        default: ab_q <= ua_pkg::AB_WAIT;
      endcase
    end
  end

  // Rate and format, fixed once detection or software has set them
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      baud_q <= ua_pkg::BAUD_RST;
      fmt_q <= ua_pkg::FMT_RST;
    end else begin
      if (wr_baud && bus.wdata[3:0] <= ua_pkg::BAUD_MAX) begin
        baud_q <= bus.wdata[3:0];
      end else if (abd_run && ab_edge) begin
        baud_q <= ab_pick;
      end
      if (wr_fmt && bus.wdata[2:0] <= ua_pkg::FMT_7O1) begin
        fmt_q <= bus.wdata[2:0];
      end else if (abd_run && ab_q == ua_pkg::AB_DONE) begin
        fmt_q <= ab_fmt;
      end
    end
  end

  // Detection never reruns once done, disabled or overridden
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      abd_done_q <= 1'b0;
    end else if ((abd_run && ab_q == ua_pkg::AB_DONE) || wr_baud || wr_fmt
                 || (wr_ctrl && !bus.wdata[ua_pkg::C_ABD_EN])) begin
      abd_done_q <= 1'b1;
    end
  end

  // Receiver on txd
  ua_pkg::ua_ln_t rx_q;
  logic [7:0] rx_sh_q;
  logic [2:0] rx_k_q;
  logic rx_par_q;
  logic rx_pe_q;
  logic rx_tick;
  logic rx_go;
  logic rx_end;
  logic [7:0] rx_byte;
  logic rx_flow;
  logic [DW-1:0] rx_first;
  logic fi_valid;
  logic fi_ready;
  logic fo_valid;
  logic [7:0] fo_data;
  logic [3:0] fo_level;

  assign rx_go = rx_q == ua_pkg::LN_IDLE && rx_en && !txd;
  assign rx_first = {1'b0, div[DW-1:1]} - ua_pkg::DIV_ONE;
  assign rx_end = rx_q == ua_pkg::LN_STOP && rx_tick;
  assign rx_byte = fmt.bits8 ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
  assign rx_flow = flow == ua_pkg::FLOW_SW
                   && (rx_byte == ua_pkg::XON || rx_byte == ua_pkg::XOFF);
  assign fi_valid = rx_end && txd && !rx_flow;

  ua_tick #(.W(DW)) u_rx_tick (
    .mclk(mclk),
    .rstn(rstn),
    .load(rx_go),
    .first(rx_first),
    .period(div),
    .tick(rx_tick)
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_q <= ua_pkg::LN_IDLE;
      rx_sh_q <= '0;
      rx_k_q <= '0;
      rx_par_q <= 1'b0;
      rx_pe_q <= 1'b0;
    end else begin
      case (rx_q)
        ua_pkg::LN_IDLE: begin
          if (rx_go) begin
            rx_q <= ua_pkg::LN_START;
          end
        end
        ua_pkg::LN_START: begin
          if (rx_tick) begin
            rx_q <= txd ? ua_pkg::LN_IDLE : ua_pkg::LN_DATA;
            rx_k_q <= '0;
            rx_par_q <= 1'b0;
            rx_pe_q <= 1'b0;
          end
        end
        ua_pkg::LN_DATA: begin
          if (rx_tick) begin
            rx_sh_q <= {txd, rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ txd;
            rx_k_q <= rx_k_q + 3'h1;
            if (rx_k_q == (fmt.bits8 ? 3'h7 : 3'h6)) begin
              rx_q <= fmt.par ? ua_pkg::LN_PAR : ua_pkg::LN_STOP;
            end
          end
        end
        ua_pkg::LN_PAR: begin
          if (rx_tick) begin
            rx_pe_q <= txd != (rx_par_q ^ fmt.odd);
            rx_q <= ua_pkg::LN_STOP;
          end
        end
        ua_pkg::LN_STOP: begin
          if (rx_tick) begin
            rx_q <= ua_pkg::LN_IDLE;
          end
        end
        default: rx_q <= ua_pkg::LN_IDLE;
      endcase
    end
  end

  // Received characters wait here; a full FIFO holds cts OFF
  ua_fifo #(.W(ua_pkg::FIFO_W), .D(ua_pkg::FIFO_D)) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(fi_valid),
    .in_ready(fi_ready),
    .in_data(rx_byte),
    .out_valid(fo_valid),
    .out_ready(rd_recv),
    .out_data(fo_data),
    .level(fo_level)
  );

  // Sticky errors and software flow state; a new event beats a clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ovr_q <= 1'b0;
      ferr_q <= 1'b0;
      perr_q <= 1'b0;
      xoff_q <= 1'b0;
    end else begin
      ovr_q <= (fi_valid && !fi_ready)
               || (ovr_q && !(wr_stat && bus.wdata[ua_pkg::S_OVR]));
      ferr_q <= (rx_end && !txd)
                || (ferr_q && !(wr_stat && bus.wdata[ua_pkg::S_FERR]));
      perr_q <= (rx_end && rx_pe_q)
                || (perr_q && !(wr_stat && bus.wdata[ua_pkg::S_PERR]));
      if (flow != ua_pkg::FLOW_SW) begin
        xoff_q <= 1'b0;
      end else if (rx_end && txd) begin
        if (rx_byte == ua_pkg::XOFF) begin
          xoff_q <= 1'b1;
        end else if (rx_byte == ua_pkg::XON) begin
          xoff_q <= 1'b0;
        end
      end
    end
  end

  // Transmitter on rxd
  ua_pkg::ua_ln_t tx_q;
  logic [7:0] txh_q;
  logic txh_v_q;
  logic [7:0] tx_sh_q;
  logic [2:0] tx_k_q;
  logic tx_par_q;
  logic tx_stop_q;
  logic rxd_q;
  logic tx_tick;
  logic tx_allow;
  logic tx_go;

  assign tx_allow = flow == ua_pkg::FLOW_HW ? !rts_n
                  : (flow == ua_pkg::FLOW_SW ? !xoff_q : 1'b1);
  assign tx_go = tx_q == ua_pkg::LN_IDLE && txh_v_q && tx_allow && !abd_run;

  ua_tick #(.W(DW)) u_tx_tick (
    .mclk(mclk),
    .rstn(rstn),
    .load(tx_go),
    .first(div - ua_pkg::DIV_ONE),
    .period(div),
    .tick(tx_tick)
  );

  // One holding byte; writes while it is full are dropped
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      txh_q <= '0;
      txh_v_q <= 1'b0;
    end else if (wr_send && !txh_v_q) begin
      txh_q <= bus.wdata[7:0];
      txh_v_q <= 1'b1;
    end else if (tx_go) begin
      txh_v_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_q <= ua_pkg::LN_IDLE;
      tx_sh_q <= '0;
      tx_k_q <= '0;
      tx_par_q <= 1'b0;
      tx_stop_q <= 1'b0;
      rxd_q <= 1'b1;
    end else begin
      case (tx_q)
        ua_pkg::LN_IDLE: begin
          if (tx_go) begin
            rxd_q <= 1'b0;
            tx_sh_q <= txh_q;
            tx_k_q <= '0;
            tx_par_q <= fmt.odd;
            tx_q <= ua_pkg::LN_START;
          end
        end
        ua_pkg::LN_START: begin
          if (tx_tick) begin
            rxd_q <= tx_sh_q[0];
            tx_par_q <= tx_par_q ^ tx_sh_q[0];
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_q <= ua_pkg::LN_DATA;
          end
        end
        ua_pkg::LN_DATA: begin
          if (tx_tick) begin
            if (tx_k_q == (fmt.bits8 ? 3'h7 : 3'h6)) begin
              rxd_q <= fmt.par ? tx_par_q : 1'b1;
              tx_stop_q <= fmt.stop2;
              tx_q <= fmt.par ? ua_pkg::LN_PAR : ua_pkg::LN_STOP;
            end else begin
              rxd_q <= tx_sh_q[0];
              tx_par_q <= tx_par_q ^ tx_sh_q[0];
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              tx_k_q <= tx_k_q + 3'h1;
            end
          end
        end
        ua_pkg::LN_PAR: begin
          if (tx_tick) begin
            rxd_q <= 1'b1;
            tx_q <= ua_pkg::LN_STOP;
          end
        end
        ua_pkg::LN_STOP: begin
          if (tx_tick) begin
            if (tx_stop_q) begin
              tx_stop_q <= 1'b0;
            end else begin
              tx_q <= ua_pkg::LN_IDLE;
            end
          end
        end
        default: tx_q <= ua_pkg::LN_IDLE;
      endcase
    end
  end

  // Host control lines and power saving
  assign sleep_d = ctrl_q[ua_pkg::C_PSV_EN]
                   && (ctrl_q[ua_pkg::C_PSV_DTR] ? dtr_n : rts_n);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sleep_q <= 1'b0;
      cts_q <= 1'b1;
      dsr_q <= 1'b1;
      dcd_q <= 1'b1;
      ri_q <= 1'b1;
    end else begin
      sleep_q <= sleep_d;
      // Two free words cover a character already on the wire
      cts_q <= sleep_d || fo_level >= ua_pkg::CTS_LVL;
      dsr_q <= !ctrl_q[ua_pkg::C_DSR];
      dcd_q <= !ctrl_q[ua_pkg::C_DCD];
      ri_q <= !ctrl_q[ua_pkg::C_RI];
    end
  end

  // Register reads answer in the next cycle only
  assign stat = {6'h00, xoff_q, sleep_q, !rts_n, !dtr_n, abd_done_q,
                 perr_q, ferr_q, ovr_q, txh_v_q, fo_valid};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        ua_pkg::A_CTRL: rdata_q <= {8'h00, ctrl_q};
        ua_pkg::A_BAUD: rdata_q <= {12'h000, baud_q};
        ua_pkg::A_FRAME: rdata_q <= {13'h0000, fmt_q};
        ua_pkg::A_STAT: rdata_q <= stat;
        ua_pkg::A_RECV: rdata_q <= {8'h00, fo_data};
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata = rdata_q;
  assign rxd = rxd_q;
  assign cts_n = cts_q;
  assign dsr_n = dsr_q;
  assign dcd_n = dcd_q;
  assign ri_n = ri_q;
  assign psv_sleep = sleep_q;
endmodule : ua_port
`default_nettype wire

// *** ua_port_assertions.sv ***
// Purpose: Port-level checks of the host serial port
// Assumes: One mclk domain, rates up to 6.5 Mbit/s
// Notes: Fastest bit lasts 15 cycles, so any bit stands at least 15
`default_nettype none
module ua_port_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire ua_pkg::ua_bus_t bus,
  input wire logic [15:0] rdata,
  // Host lines and power saving state
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic ri_n,
  input wire logic psv_sleep
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic ctrl_wr;
  assign ctrl_wr = bus.wr && bus.addr == ua_pkg::A_CTRL;
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_rxd_reset: assert property (!$past(rstn) |-> rxd)
    else $error("rxd not idle after reset");
  a_cts_ready: assert property (!$past(rstn) |-> ##[0:2] !cts_n)
    else $error("cts not on after reset");
  a_sleep_cts: assert property (psv_sleep && $past(psv_sleep) |-> cts_n)
    else $error("cts on while sleeping");
  // Control lands one edge after the write, the modem line one edge after that
  a_dsr_follow: assert property (ctrl_wr |-> ##2
    dsr_n == !$past(bus.wdata[ua_pkg::C_DSR], 2))
    else $error("dsr does not follow control");
  a_dcd_hold: assert property (!ctrl_wr |-> ##2 $stable(dcd_n))
    else $error("dcd moved without write");
  a_ri_follow: assert property (ctrl_wr |-> ##2
    ri_n != $past(bus.wdata[ua_pkg::C_RI], 2))
    else $error("ri polarity wrong");
  a_bit_width: assert property ($changed(rxd) |=> $stable(rxd)[*8] ##1 $stable(rxd)[*6])
    else $error("rxd bit too short");
  a_start_low: assert property ($fell(rxd) |-> !rxd[*8] ##1 !rxd[*6])
    else $error("start bit too short");
endmodule : ua_port_chk
bind ua_port ua_port_chk chk (.mclk(mclk), .rstn(rstn), .bus(bus), .rdata(rdata), .rxd(rxd),
  .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n), .psv_sleep(psv_sleep));
`default_nettype wire

// *** ua_host.sv ***
// Purpose: Terminal-side model driving txd and watching rxd
// Assumes: Bench picks the format, rate fixed by DV
// Notes: Receiver decodes 8N1 only; stop checked once
`default_nettype none
module ua_host #(parameter int DV = 15) (
  // Clock
  input wire logic mclk,
  // From the port, and obey from the bench
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic obey,
  // To the port
  output logic txd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_byte = 8'h00;
  int rx_cnt = 0;
  initial txd = 1'b1;
  // One rate and format per character; bad flips the parity bit
  task automatic send(input logic [7:0] d, input logic [2:0] f, input logic bad);
    int k;
    logic [11:0] v;
    v = 12'hfff;
    v[0] = 1'b0;
    k = (f < 3'h4) ? 8 : 7;
    for (int i = 0; i < k; i++) v[1 + i] = d[i];
    k++;
    if (f > 3'h1) begin
      v[k] = ^(d & ((f < 3'h4) ? 8'hff : 8'h7f)) ^ (f == 3'h3 || f == 3'h5) ^ bad;
      k++;
    end
    for (int t = 0; t < 30000 && obey && cts_n !== 1'b0; t++) @(posedge mclk);
    for (int i = 0; i < k + 1 + int'(f == 3'h0); i++) begin
      txd <= v[i];
      repeat (DV) @(posedge mclk);
    end
  endtask : send
  always begin
    @(negedge rxd);
    repeat (DV / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (DV) @(posedge mclk);
      rx_byte[i] = rxd;
    end
    repeat (DV) @(posedge mclk);
    if (rxd === 1'b1) rx_cnt++;
  end
endmodule : ua_host
`default_nettype wire

// *** test_ua_port.sv ***
// Purpose: Self-checking bench of the host serial port
// Assumes: Detection settles on 6.5 Mbit/s to keep frames short
// Notes: Flow, fifo, parity and sleep cases share the bus tasks
`default_nettype none
module test_ua_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DV = 15; // Nearest divisor of 100 MHz to 6.5 Mbit/s
  logic mclk, rstn, txd, rts_n, dtr_n, rxd, cts_n, dsr_n, dcd_n, ri_n, psv_sleep, obey;
  ua_pkg::ua_bus_t bus;
  logic [15:0] rdata;
  int fail_count = 0, checked = 0, cyc = 0;
  ua_port uut (.mclk(mclk), .rstn(rstn), .bus(bus), .rdata(rdata), .txd(txd), .rts_n(rts_n),
    .dtr_n(dtr_n), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n),
    .psv_sleep(psv_sleep));
  ua_host #(.DV(DV)) host (.mclk(mclk), .rxd(rxd), .cts_n(cts_n), .obey(obey), .txd(txd));
  always #5 mclk = ~mclk;
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    chk(rdata, e);
    @(posedge mclk);
  endtask : rd
  // Holding byte is sent, or held back, by the flow mode in force
  task automatic tx(input logic w, input logic [7:0] d, input logic go);
    int n;
    n = host.rx_cnt;
    if (w) wr(ua_pkg::A_SEND, {8'h00, d});
    for (int t = 0; t < 400 && host.rx_cnt == n; t++) @(posedge mclk);
    chk(16'(host.rx_cnt != n), 16'(go));
    if (go) chk(16'(host.rx_byte), 16'(d));
  endtask : tx
  task automatic slp(input logic e);
    repeat (3) @(posedge mclk);
    for (int t = 0; t < 8 && psv_sleep !== e; t++) @(posedge mclk);
    @(negedge mclk);
    chk(16'({psv_sleep, cts_n}), 16'({e, e}));
    @(posedge mclk);
  endtask : slp
  initial begin
    mclk = 1'b0;
    obey = 1'b1;
    bus = '0;
    {rstn, rts_n, dtr_n} = 3'h0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd(ua_pkg::A_CTRL, 16'h0010);
    rd(ua_pkg::A_BAUD, 16'h0004);
    rd(ua_pkg::A_FRAME, 16'h0001);
    rd(8'h20, 16'h0000);
    host.send(8'h41, ua_pkg::FMT_8N1, 1'b0);
    rd(ua_pkg::A_BAUD, 16'h000b);
    rd(ua_pkg::A_FRAME, 16'h0001);
    rd(ua_pkg::A_STAT, 16'h00e0);
    wr(ua_pkg::A_BAUD, 16'h000c);
    rd(ua_pkg::A_BAUD, 16'h000b);
    for (int f = 0; f < 6; f++) begin
      wr(ua_pkg::A_FRAME, 16'(f));
      host.send(8'ha6 + 8'(f), 3'(f), 1'b0);
      rd(ua_pkg::A_RECV, (f < 4) ? 16'h00a6 + 16'(f) : 16'h0026 + 16'(f));
    end
    rd(ua_pkg::A_STAT, 16'h00e0);
    wr(ua_pkg::A_FRAME, 16'h0002);
    host.send(8'h3c, ua_pkg::FMT_8E1, 1'b1);
    rd(ua_pkg::A_STAT, 16'h00f1);
    rd(ua_pkg::A_RECV, 16'h003c);
    wr(ua_pkg::A_STAT, 16'h0010);
    wr(ua_pkg::A_FRAME, 16'h0001);
    for (int i = 0; i < 6; i++) host.send(8'(i), ua_pkg::FMT_8N1, 1'b0);
    chk(16'(cts_n), 16'h0001);
    obey <= 1'b0;
    for (int i = 6; i < 9; i++) host.send(8'(i), ua_pkg::FMT_8N1, 1'b0);
    rd(ua_pkg::A_STAT, 16'h00e5);
    for (int i = 0; i < 8; i++) rd(ua_pkg::A_RECV, 16'(i));
    @(negedge mclk);
    chk(16'(cts_n), 16'h0000);
    @(posedge mclk);
    obey <= 1'b1;
    wr(ua_pkg::A_STAT, 16'h0004);
    wr(ua_pkg::A_CTRL, 16'h00e0);
    @(negedge mclk);
    chk(16'({dsr_n, dcd_n, ri_n}), 16'h0000);
    @(posedge mclk);
    rts_n <= 1'b1;
    tx(1'b1, 8'h33, 1'b0);
    rts_n <= 1'b0;
    tx(1'b0, 8'h33, 1'b1);
    wr(ua_pkg::A_CTRL, 16'h0002);
    rts_n <= 1'b1;
    tx(1'b1, 8'h44, 1'b1);
    rts_n <= 1'b0;
    wr(ua_pkg::A_CTRL, 16'h0001);
    host.send(ua_pkg::XOFF, ua_pkg::FMT_8N1, 1'b0);
    tx(1'b1, 8'h55, 1'b0);
    host.send(ua_pkg::XON, ua_pkg::FMT_8N1, 1'b0);
    tx(1'b0, 8'h55, 1'b1);
    wr(ua_pkg::A_CTRL, 16'h000c);
    dtr_n <= 1'b1;
    slp(1'b1);
    wr(ua_pkg::A_CTRL, 16'h0004);
    slp(1'b0);
    rts_n <= 1'b1;
    slp(1'b1);
    end_sim();
  end
endmodule : test_ua_port
`default_nettype wire
